// ==== verilog/fcg_pkg.sv ====
// Constants, types and decode helpers for the frequency counter gate control
package fcg_pkg;
    // Clock and time base rates in kHz
    localparam int CLK_KHZ = 100000;
    localparam int TICK_KHZ = 1;
    localparam int REF_MID_KHZ = 100;
    localparam int REF_HI_KHZ = 900;
    localparam int NUM_RATES = 3;
    localparam int RATE_KHZ [NUM_RATES] = '{TICK_KHZ, REF_MID_KHZ, REF_HI_KHZ};
    localparam int RATE_TICK = 0;
    localparam int RATE_MID = 1;
    localparam int RATE_HI = 2;
    localparam int ACC_W = 17;
    // Gate times in ms; one tick lasts 1000 / TICK_KHZ us
    localparam int GATE_A_MS = 1;
    localparam int GATE_B_MS = 4;
    localparam int GATE_C_MS = 8;
    localparam int TICK_US = 1000 / TICK_KHZ;
    localparam logic [3:0] GATE_A_TICKS = 4'(GATE_A_MS * 1000 / TICK_US);
    localparam logic [3:0] GATE_B_TICKS = 4'(GATE_B_MS * 1000 / TICK_US);
    localparam logic [3:0] GATE_C_TICKS = 4'(GATE_C_MS * 1000 / TICK_US);
    // Register indices; byte address is four times the index
    localparam int ADDR_W = 10;
    localparam logic [7:0] IDX_MODE = 8'h12;
    localparam logic [7:0] IDX_CTRL = 8'h23;
    localparam logic [7:0] IDX_GATE = 8'h04;
    localparam logic [7:0] IDX_IRQ = 8'h3A;
    localparam logic [7:0] IDX_DATA = 8'h40;
    localparam logic [7:0] IDX_MASK = 8'h41;
    localparam logic [7:0] IDX_PORT = 8'h42;
    localparam logic [ADDR_W-1:0] ADDR_MODE = {IDX_MODE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_GATE = {IDX_GATE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ = {IDX_IRQ, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_DATA = {IDX_DATA, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_PORT = {IDX_PORT, 2'h0};
    // Field layout
    localparam int MODE_W = 4;
    localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
    localparam int TIME_LSB = 0;
    localparam int FUNC_LSB = 2;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam int FLAG_BIT = 0;
    localparam int PORT_DIR_BIT = 0;
    localparam int PORT_DOUT_BIT = 1;
    localparam int CNT_W = 16;
    // Function and timing encodings
    localparam logic [1:0] FUNC_CGP = 2'h0;
    localparam logic [1:0] FUNC_FM = 2'h1;
    localparam logic [1:0] FUNC_AM = 2'h2;
    localparam logic [1:0] FUNC_EXT = 2'h3;
    localparam logic [1:0] TIME_A = 2'h0;
    localparam logic [1:0] TIME_B = 2'h1;
    localparam logic [1:0] TIME_C = 2'h2;
    localparam logic [1:0] TIME_OPEN = 2'h3;

    typedef enum logic [2:0] {
        FCG_IDLE,
        FCG_WAIT_TICK,
        FCG_IF_OPEN,
        FCG_EXT_ARM,
        FCG_EXT_OPEN
    } fcg_state_t;

    function automatic logic fcg_is_if(input logic [1:0] func);
        fcg_is_if = (func == FUNC_FM) || (func == FUNC_AM);
    endfunction : fcg_is_if
endpackage : fcg_pkg

// ==== verilog/fcg_rate_gen.sv ====
// Fractional rate generator: one-cycle enables at 1, 100 and 900 kHz
`timescale 1ns/100ps
module fcg_rate_gen
    import fcg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Rate enables
    output logic [NUM_RATES-1:0] rate_en_o
);
    logic [ACC_W-1:0] acc_r [NUM_RATES];
    logic [ACC_W-1:0] acc_nxt [NUM_RATES];
    logic [NUM_RATES-1:0] en_r;
    logic [NUM_RATES-1:0] en_nxt;

    // Phase accumulator keeps 900 kHz exact although 100 MHz does not divide it
    genvar g;
    generate
        for (g = 0; g < NUM_RATES; g++) begin : g_rate
            always_comb begin
                logic [ACC_W-1:0] sum;
                sum = acc_r[g] + ACC_W'(RATE_KHZ[g]);
                en_nxt[g] = (sum >= ACC_W'(CLK_KHZ));
                acc_nxt[g] = en_nxt[g] ? sum - ACC_W'(CLK_KHZ) : sum;
            end
            always_ff @(posedge clock_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    acc_r[g] <= '0;
                    en_r[g] <= 1'b0;
                end else begin
                    acc_r[g] <= acc_nxt[g];
                    en_r[g] <= en_nxt[g];
                end
            end
        end
    endgenerate

    assign rate_en_o = en_r;
endmodule : fcg_rate_gen

// ==== verilog/fcg_edge_det.sv ====
// Rising edge detector for a group of synchronous inputs
`timescale 1ns/100ps
module fcg_edge_det #(
    parameter int N = 3
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Levels in, strobes out
    input wire logic [N-1:0] level_i,
    output logic [N-1:0] rise_o
);
    logic [N-1:0] prev_r;
    logic [N-1:0] prev_nxt;

    always_comb begin
        prev_nxt = level_i;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_r <= '0;
        end else begin
            prev_r <= prev_nxt;
        end
    end

    assign rise_o = level_i & ~prev_r;
endmodule : fcg_edge_det

// ==== verilog/fcg_gate_ctrl.sv ====
// Frequency counter gate control: pin select, gate timing, count and flags
// Function
// RULE1: The function select field picks CLOCK_GENERATOR_PORT, FM IF count, AM IF count or external gate.
// RULE2: The timing field sets 1/4/8 ms or open gate, and 1/100/900 kHz or no reference.
// RULE3: With the gate pin direction bit at 1 the pin is a plain output in every mode.
// RULE4: Only the one selected function may be active at a time.
// RULE5: Counting starts only after software sets the start flag.
// RULE6: A finite IF gate opens on the next 1 kHz tick and stays open the set time.
// RULE7: While the IF gate is open the 16-bit count steps on each selected input edge.
// RULE8: Closing the IF gate clears the gate-open flag and sets the done flag together.
// RULE9: Setting the start flag sets the gate-open flag.
// RULE10: The done flag clears on interrupt acceptance or a write of 0, else stays.
// RULE11: In external gate mode the gate-open flag stays set; only the done flag ends it.
// RULE12: The count wraps from its top value to zero and goes on.
// RULE13: Writing 1 to the clear flag zeroes the count.
// RULE14: The FM input is halved before counting; the AM input is not.
// RULE15: An open gate stays open; counting stops on deselect or a finite gate time.
// RULE16: A start during an open finite IF gate restarts and waits for the next tick.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module fcg_gate_ctrl
    import fcg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Interrupt
    output logic irq_o,
    input wire logic irq_ack_i,
    // IF inputs
    input wire logic fm_if_input_i,
    input wire logic am_if_input_i,
    // Gate pin, two-way
    input wire logic external_gate_input_i,
    output logic gate_pin_o,
    output logic gate_pin_oe_o,
    // Pin role indications
    output logic clock_generator_port_o,
    output logic fm_pin_cnt_o,
    output logic am_pin_cnt_o,
    output logic gate_pin_cnt_o
);
    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] mode_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic [1:0] port_r;
    logic [1:0] port_nxt;
    logic gate_flag_r;
    logic gate_flag_nxt;
    logic done_flag_r;
    logic done_flag_nxt;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    logic fm_half_r;
    logic fm_half_nxt;
    logic [3:0] ticks_r;
    logic [3:0] ticks_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    fcg_state_t state_r;
    fcg_state_t state_nxt;

    logic [1:0] func_sel;
    logic [1:0] time_sel;
    logic wr_en;
    logic rd_setup;
    logic mapped;
    logic start_wr;
    logic clear_wr;
    logic [NUM_RATES-1:0] rate_en;
    logic [2:0] rise;
    logic tick;
    logic ref_en;
    logic if_edge;
    logic gate_edge;
    logic close_if;
    logic close_ext;
    logic [3:0] gate_ticks;

    fcg_rate_gen u_rate (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .rate_en_o(rate_en)
    );

    fcg_edge_det #(.N(3)) u_edge (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .level_i({external_gate_input_i, am_if_input_i, fm_if_input_i}),
        .rise_o(rise)
    );

    assign func_sel = mode_r[FUNC_LSB +: 2];
    assign time_sel = mode_r[TIME_LSB +: 2];

    // Bus decode; slave is always ready in the access phase
    assign mapped = (paddr_i == ADDR_MODE) || (paddr_i == ADDR_CTRL) ||
                    (paddr_i == ADDR_GATE) || (paddr_i == ADDR_IRQ) ||
                    (paddr_i == ADDR_DATA) || (paddr_i == ADDR_MASK) ||
                    (paddr_i == ADDR_PORT);
    assign pready_o = psel_i & penable_i;
    assign pslverr_o = psel_i & penable_i & ~mapped;
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
    // Start ignored while the CLOCK_GENERATOR_PORT function owns the shared counter
    assign start_wr = wr_en && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_START_BIT] &&
                      (func_sel != FUNC_CGP); // RULE4 RULE5
    assign clear_wr = wr_en && (paddr_i == ADDR_CTRL) && pwdata_i[CTRL_CLEAR_BIT];

    // Pin roles, one function at a time
    assign clock_generator_port_o = (func_sel == FUNC_CGP); // RULE1 RULE4
    assign fm_pin_cnt_o = (func_sel == FUNC_FM); // RULE1
    assign am_pin_cnt_o = (func_sel == FUNC_AM); // RULE1
    assign gate_pin_cnt_o = (func_sel == FUNC_EXT) && !port_r[PORT_DIR_BIT]; // RULE1 RULE3
    assign gate_pin_oe_o = port_r[PORT_DIR_BIT]; // RULE3
    assign gate_pin_o = port_r[PORT_DOUT_BIT]; // RULE3

    // Time base and count sources
    assign tick = rate_en[RATE_TICK];
    always_comb begin
        unique case (time_sel) // RULE2
            TIME_A: begin
                gate_ticks = GATE_A_TICKS;
                ref_en = rate_en[RATE_TICK];
            end
            TIME_B: begin
                gate_ticks = GATE_B_TICKS;
                ref_en = rate_en[RATE_MID];
            end
            TIME_C: begin
                gate_ticks = GATE_C_TICKS;
                ref_en = rate_en[RATE_HI];
            end
            TIME_OPEN: begin
                gate_ticks = '0;
                ref_en = 1'b0;
            end
        endcase
    end

    // FM edges counted every second one; deselected pins count nothing
    assign if_edge = ((func_sel == FUNC_FM) && rise[0] && fm_half_r) ||
                     ((func_sel == FUNC_AM) && rise[1]); // RULE14 RULE15
    // Gate pin ignored while it is driven as a port output
    assign gate_edge = rise[2] && gate_pin_cnt_o; // RULE3
    assign close_if = (state_r == FCG_IF_OPEN) && tick && (time_sel != TIME_OPEN) &&
                      (ticks_r + 4'h1 >= gate_ticks); // RULE6 RULE15
    assign close_ext = (state_r == FCG_EXT_OPEN) && gate_edge;

    // Gate sequencer
    always_comb begin
        state_nxt = state_r;
        ticks_nxt = ticks_r;
        if (start_wr) begin
            ticks_nxt = '0;
            state_nxt = fcg_is_if(func_sel) ? FCG_WAIT_TICK : FCG_EXT_ARM; // RULE5 RULE16
        end else begin
            unique case (state_r)
                FCG_IDLE: begin
                end
                FCG_WAIT_TICK: begin
                    if (tick) begin
                        state_nxt = FCG_IF_OPEN; // RULE6
                    end
                end
                FCG_IF_OPEN: begin
                    if (close_if) begin
                        state_nxt = FCG_IDLE;
                    end else if (tick && time_sel != TIME_OPEN) begin
                        ticks_nxt = ticks_r + 4'h1;
                    end
                end
                FCG_EXT_ARM: begin
                    if (gate_edge) begin
                        state_nxt = FCG_EXT_OPEN;
                    end
                end
                FCG_EXT_OPEN: begin
                    if (close_ext) begin
                        state_nxt = FCG_IDLE;
                    end
                end
                default: begin
                    state_nxt = FCG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= FCG_IDLE;
            ticks_r <= '0;
        end else begin
            state_r <= state_nxt;
            ticks_r <= ticks_nxt;
        end
    end

    // Count and FM prescaler
    always_comb begin
        count_nxt = count_r;
        fm_half_nxt = fm_half_r;
        if (start_wr) begin
            fm_half_nxt = 1'b0;
        end else if ((func_sel == FUNC_FM) && rise[0] && state_r == FCG_IF_OPEN) begin
            fm_half_nxt = ~fm_half_r; // RULE14
        end
        if (clear_wr) begin
            count_nxt = '0; // RULE13
        end else if (state_r == FCG_IF_OPEN && if_edge) begin
            count_nxt = count_r + 16'h0001; // RULE7 RULE12
        end else if (state_r == FCG_EXT_OPEN && func_sel == FUNC_EXT && ref_en) begin
            count_nxt = count_r + 16'h0001; // RULE2 RULE12
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_r <= '0;
            fm_half_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            fm_half_r <= fm_half_nxt;
        end
    end

    // Flags; hardware set wins over any clear in the same cycle
    always_comb begin
        gate_flag_nxt = gate_flag_r;
        done_flag_nxt = done_flag_r;
        if (close_if) begin
            gate_flag_nxt = 1'b0; // RULE8
        end
        if (start_wr) begin
            gate_flag_nxt = 1'b1; // RULE9 RULE11
        end
        if (irq_ack_i || (wr_en && paddr_i == ADDR_IRQ && !pwdata_i[FLAG_BIT])) begin
            done_flag_nxt = 1'b0; // RULE10
        end
        if (close_if || close_ext) begin
            done_flag_nxt = 1'b1; // RULE8 RULE11
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            gate_flag_r <= 1'b0;
            done_flag_r <= 1'b0;
        end else begin
            gate_flag_r <= gate_flag_nxt;
            done_flag_r <= done_flag_nxt;
        end
    end

    assign irq_o = done_flag_r & mask_r[FLAG_BIT];

    // Software registers and read data captured in the setup cycle
    always_comb begin
        mode_nxt = mode_r;
        mask_nxt = mask_r;
        port_nxt = port_r;
        prdata_nxt = prdata_r;
        if (wr_en) begin
            unique case (paddr_i)
                ADDR_MODE: mode_nxt = pwdata_i[MODE_W-1:0]; // RULE1 RULE2
                ADDR_MASK: mask_nxt = pwdata_i[1:0];
                ADDR_PORT: port_nxt = pwdata_i[1:0];
                default: begin
                end
            endcase
        end
        if (rd_setup) begin
            unique case (paddr_i)
                ADDR_MODE: prdata_nxt = {28'h0, mode_r};
                ADDR_GATE: prdata_nxt = {31'h0, gate_flag_r};
                ADDR_IRQ: prdata_nxt = {31'h0, done_flag_r};
                ADDR_DATA: prdata_nxt = {16'h0, count_r};
                ADDR_MASK: prdata_nxt = {30'h0, mask_r};
                ADDR_PORT: prdata_nxt = {30'h0, port_r};
                default: prdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_r <= MODE_RESET;
            mask_r <= '0;
            port_r <= '0;
            prdata_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            mask_r <= mask_nxt;
            port_r <= port_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata_o = prdata_r;
endmodule : fcg_gate_ctrl

// ==== verification/fcg_gate_ctrl_asserts.sv ====
// Port level checks for the gate control block
`timescale 1ns/100ps
module fcg_gate_ctrl_asserts
    import fcg_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // APB
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Interrupt
    input wire logic irq_o,
    input wire logic irq_ack_i,
    // Pin roles
    input wire logic gate_pin_oe_o,
    input wire logic clock_generator_port_o,
    input wire logic fm_pin_cnt_o,
    input wire logic am_pin_cnt_o,
    input wire logic gate_pin_cnt_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic wr_acc;
    logic irq_wr;
    logic port_wr;
    logic mode_wr;
    logic [3:0] roles;
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign irq_wr = wr_acc && (paddr_i == ADDR_IRQ || paddr_i == ADDR_MASK);
    assign port_wr = wr_acc && paddr_i == ADDR_PORT;
    assign mode_wr = wr_acc && paddr_i == ADDR_MODE;
    assign roles = {clock_generator_port_o, fm_pin_cnt_o, am_pin_cnt_o, gate_pin_cnt_o};

    property p_roles_exclusive;
        $onehot0(roles);
    endproperty
    a_roles_exclusive: assert property (p_roles_exclusive) else $error("two pin roles");
    property p_roles_by_write;
        $changed(roles) |-> $past(mode_wr) || $past(port_wr);
    endproperty
    a_roles_by_write: assert property (p_roles_by_write) else $error("role moved");
    property p_gate_role_input;
        gate_pin_cnt_o |-> !gate_pin_oe_o;
    endproperty
    a_gate_role_input: assert property (p_gate_role_input) else $error("gate pin driven");
    property p_oe_by_write;
        $changed(gate_pin_oe_o) |-> $past(port_wr);
    endproperty
    a_oe_by_write: assert property (p_oe_by_write) else $error("enable moved");
    property p_ack_clears;
        (irq_ack_i && irq_o) |=> !irq_o;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack ignored");
    property p_irq_holds;
        $fell(irq_o) |-> $past(irq_ack_i) || $past(irq_wr);
    endproperty
    a_irq_holds: assert property (p_irq_holds) else $error("irq dropped");
    // Zero wait slave: a late ready would stall every master
    property p_ready_access;
        (psel_i && !penable_i) ##1 penable_i |-> pready_o;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready missing");
    property p_err_access;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    a_err_access: assert property (p_err_access) else $error("stray error");
endmodule : fcg_gate_ctrl_asserts

bind fcg_gate_ctrl fcg_gate_ctrl_asserts i_chk (
    .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .irq_o(irq_o), .irq_ack_i(irq_ack_i), .gate_pin_oe_o(gate_pin_oe_o),
    .clock_generator_port_o(clock_generator_port_o), .fm_pin_cnt_o(fm_pin_cnt_o),
    .am_pin_cnt_o(am_pin_cnt_o), .gate_pin_cnt_o(gate_pin_cnt_o)
);

// ==== verification/fcg_sig_src.sv ====
// IF waves and external gate pulses from the far side
`timescale 1ns/100ps
module fcg_sig_src (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rstn_i,
    // Wave half period, gate pulse period
    input wire logic [15:0] half_i,
    input wire logic [15:0] gate_per_i,
    // Pin levels
    output logic fm_o,
    output logic am_o,
    output logic gate_o
);
    logic [15:0] if_cnt_r;
    logic [15:0] gate_cnt_r;
    // Synchronous waves; both share a phase, only one pin is selected
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            if_cnt_r <= 16'h0;
            gate_cnt_r <= 16'h0;
            fm_o <= 1'b0;
            am_o <= 1'b0;
            gate_o <= 1'b0;
        end else begin
            if_cnt_r <= (if_cnt_r == half_i - 16'h1) ? 16'h0 : if_cnt_r + 16'h1;
            if (if_cnt_r == half_i - 16'h1) begin
                fm_o <= !fm_o;
                am_o <= !am_o;
            end
            gate_cnt_r <= (gate_cnt_r == gate_per_i - 16'h1) ? 16'h0 : gate_cnt_r + 16'h1;
            gate_o <= gate_cnt_r < (gate_per_i >> 1);
        end
    end
endmodule : fcg_sig_src

// ==== verification/tb.sv ====
// Self-checking bench for the gate control block
`timescale 1ns/100ps
module tb;
    import fcg_pkg::*;
    localparam int GATE_PER = 2000;
    localparam int IF_HALF = 50;
    localparam int LIMIT = 300000;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic irq_ack = 1'b0;
    logic fm;
    logic am;
    logic src_gate;
    logic pin_in;
    logic pin_o;
    logic pin_oe;
    logic [3:0] roles;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    logic [1:0] codes [3] = '{TIME_OPEN, TIME_B, TIME_C};

    always #5 clock_i = ~clock_i;
    // Pin level: the block wins while it drives
    assign pin_in = pin_oe ? pin_o : src_gate;

    fcg_gate_ctrl i_dut (
        .clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .irq_ack_i(irq_ack),
        .fm_if_input_i(fm), .am_if_input_i(am), .external_gate_input_i(pin_in),
        .gate_pin_o(pin_o), .gate_pin_oe_o(pin_oe), .clock_generator_port_o(roles[3]),
        .fm_pin_cnt_o(roles[2]), .am_pin_cnt_o(roles[1]), .gate_pin_cnt_o(roles[0])
    );
    fcg_sig_src i_src (
        .clock_i(clock_i), .rstn_i(rstn_i), .half_i(16'(IF_HALF)),
        .gate_per_i(16'(GATE_PER)), .fm_o(fm), .am_o(am), .gate_o(src_gate)
    );

    task automatic report_and_stop();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask : wr

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h0, q, e);
        chk(q, exp);
    endtask : rd_chk

    task automatic t_regs();
        logic [ADDR_W-1:0] map [7] = '{ADDR_MODE, ADDR_CTRL, ADDR_GATE, ADDR_IRQ,
                                       ADDR_DATA, ADDR_MASK, ADDR_PORT};
        logic [31:0] q;
        logic e;
        foreach (map[i]) rd_chk(map[i], 32'h0);
        apb(10'h3FC, 1'b0, 32'h0, q, e);
        chk({e, q[30:0]}, 32'h8000_0000);
        chk({28'h0, roles}, 32'h8);
        wr(ADDR_CTRL, 32'h1);
        rd_chk(ADDR_GATE, 32'h0);
    endtask : t_regs

    task automatic t_roles();
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_MODE, 32'hFFFF_FFF0 | 32'(i * 5));
            rd_chk(ADDR_MODE, 32'(i * 5));
            @(negedge clock_i);
            chk({28'h0, roles}, 32'(4'h8 >> i));
        end
        wr(ADDR_PORT, 32'h3);
        @(negedge clock_i);
        chk({29'h0, roles[0], pin_oe, pin_o}, 32'h3);
        wr(ADDR_PORT, 32'h0);
        @(negedge clock_i);
        chk({29'h0, roles[0], pin_oe, pin_o}, 32'h4);
    endtask : t_roles

    task automatic t_ext(input logic [1:0] t);
        int n;
        int exp;
        n = 0;
        exp = (t == TIME_OPEN) ? 0 : RATE_KHZ[t] * GATE_PER / CLK_KHZ;
        wr(ADDR_MODE, {28'h0, FUNC_EXT, t});
        wr(ADDR_IRQ, 32'h0);
        wr(ADDR_CTRL, 32'h3);
        // Look at the level between edges, never in the edge that sets it
        while (irq !== 1'b1 && n < 4 * GATE_PER) begin
            @(negedge clock_i);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        rd_chk(ADDR_GATE, 32'h1);
        rd_chk(ADDR_DATA, 32'(exp));
        wr(ADDR_IRQ, 32'h0);
        @(negedge clock_i);
        chk({31'h0, irq}, 32'h0);
    endtask : t_ext

    task automatic t_clear();
        wr(ADDR_CTRL, 32'h2);
        rd_chk(ADDR_DATA, 32'h0);
    endtask : t_clear

    task automatic t_if();
        logic [31:0] q;
        logic e;
        int n;
        n = 0;
        q = 32'h1;
        wr(ADDR_MASK, 32'h0);
        wr(ADDR_MODE, {28'h0, FUNC_FM, TIME_A});
        wr(ADDR_CTRL, 32'h3);
        rd_chk(ADDR_GATE, 32'h1);
        // Gate waits for the slow tick; poll the flag with the mask off
        while (q[0] === 1'b1 && n < 100000) begin
            apb(ADDR_GATE, 1'b0, 32'h0, q, e);
            n++;
        end
        rd_chk(ADDR_IRQ, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rd_chk(ADDR_DATA, 32'(CLK_KHZ / TICK_KHZ * GATE_A_MS / (4 * IF_HALF)));
        wr(ADDR_MASK, 32'h1);
        @(negedge clock_i);
        chk({31'h0, irq}, 32'h1);
        @(posedge clock_i);
        irq_ack <= 1'b1;
        @(posedge clock_i);
        irq_ack <= 1'b0;
        @(negedge clock_i);
        chk({31'h0, irq}, 32'h0);
        rd_chk(ADDR_IRQ, 32'h0);
    endtask : t_if

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs();
        t_roles();
        wr(ADDR_MASK, 32'h1);
        foreach (codes[i]) t_ext(codes[i]);
        t_clear();
        t_if();
        report_and_stop();
    end
endmodule : tb
